// [hdl/uart_baud_select_txrx_control.sv]
// Baud selection, transmitter enable/disable sequencing and receiver reset control.
// Assumes host strobes are one-cycle pulses on clk; ext_clock_pin is asynchronous.
`timescale 1ns/10ps
`include "uart_cfg.svh"

// Summary of operation
// - Disable within 3/16 bit (16x) or one bit (1x) of start sends nothing.
// - Disable right after one character loaded in underrun discards that character.
// - Shifter empty flag is set in underrun and right after enable.
// - Holding data moves to shifter in start bit; free flag sets at its end.
// - Normal mode maps each clock select code and rate set bit to a rate.
// - Generator test mode substitutes the extended rate set for codes 0000 to 0110, 1000 and 1010.
// - Code 1101 selects timer, 1110 external pin 16x, 1111 external pin 1x.
// - Each toggling read flips generator test mode for both directions together.
// - Port test mode forces 1x clocking and shows internal nodes on outputs.
// - Receiver reset then enable restarts receiver; settings stay unchanged.
// - With wake-up mode field 11, receiver disable and reset have no effect.
module uart_baud_select_txrx_control (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Rate configuration
  input wire logic [3:0] clock_select_tx,
  input wire logic [3:0] clock_select_rx,
  input wire logic aux_control_rate_set,
  input wire logic test_toggle_read,
  input wire logic port_test_mode,
  input wire logic timer_tick,
  input wire logic ext_clock_pin,
  // Transmitter control
  input wire logic tx_enable_cmd,
  input wire logic tx_disable_cmd,
  input wire logic holding_load,
  input wire logic [7:0] holding_data,
  // Receiver control
  input wire logic rx_enable_cmd,
  input wire logic rx_disable_cmd,
  input wire logic rx_reset_cmd,
  input wire logic [1:0] mode_reg_one_wake,
  // Status
  output logic baud_test_mode,
  output logic tx_holding_free_flag,
  output logic tx_shifter_empty_flag,
  output logic rx_enabled,
  output logic rx_reset_pulse,
  output logic rx_clock_tick,
  output logic rx_one_x,
  // Line and test ports
  output logic txd,
  output logic [3:0] test_port_out
);

  typedef struct packed {
    logic test_mode;
    logic tx_on;
    logic hold_full;
    logic [7:0] hold_data;
    logic [7:0] shift;
    logic [2:0] bit_cnt;
    logic [3:0] sub;
    uart_pkg::tx_state_t st;
    logic txd;
    logic rx_on;
    logic rx_rst;
    logic ext_s1;
    logic ext_s2;
    logic ext_prev;
    logic [3:0] test_out;
  } ctl_state_t;

  ctl_state_t q;
  ctl_state_t next_q;
  logic ext_edge;
  logic tx_tick;
  logic tx_one_x;
  logic bit_tick;
  logic early;
  logic wake;

  // ****************************************************************
  // Rate selection per direction
  // ****************************************************************
  assign ext_edge = q.ext_s2 && !q.ext_prev;

  baud_select tx_sel (
    .clk(clk),
    .resetn(resetn),
    .code(clock_select_tx),
    .rate_set(aux_control_rate_set),
    .test_mode(q.test_mode),
    .force_1x(port_test_mode),
    .timer_tick(timer_tick),
    .ext_edge(ext_edge),
    .tick(tx_tick),
    .one_x(tx_one_x)
  );

  baud_select rx_sel (
    .clk(clk),
    .resetn(resetn),
    .code(clock_select_rx),
    .rate_set(aux_control_rate_set),
    .test_mode(q.test_mode),
    .force_1x(port_test_mode),
    .timer_tick(timer_tick),
    .ext_edge(ext_edge),
    .tick(rx_clock_tick),
    .one_x(rx_one_x)
  );

  // ****************************************************************
  // Next state
  // ****************************************************************
  // A 1x clock has no sub-bit phase, so the whole start bit counts as early.
  assign bit_tick = tx_tick && (tx_one_x || (q.sub == `SUB_LAST));
  assign early = (q.st == uart_pkg::TX_START) && (tx_one_x || (q.sub < `EARLY_16X));
  assign wake = (mode_reg_one_wake == `WAKE_MODE);

  always_comb begin
    next_q = q;
    next_q.ext_s1 = ext_clock_pin;
    next_q.ext_s2 = q.ext_s1;
    next_q.ext_prev = q.ext_s2;
    next_q.rx_rst = 1'b0;
    if (test_toggle_read) begin
      next_q.test_mode = !q.test_mode;
    end
    if (tx_tick && !tx_one_x) begin
      next_q.sub = q.sub + 4'h1;
    end
    if (tx_enable_cmd) begin
      next_q.tx_on = 1'b1;
    end
    if (holding_load && !q.hold_full) begin
      next_q.hold_full = 1'b1;
      next_q.hold_data = holding_data;
    end
    case (q.st)
      uart_pkg::TX_IDLE: begin
        if (bit_tick && q.tx_on && q.hold_full) begin
          next_q.st = uart_pkg::TX_START;
          next_q.txd = 1'b0;
          next_q.shift = q.hold_data;
          next_q.bit_cnt = 3'h0;
        end
      end
      uart_pkg::TX_START: begin
        if (bit_tick) begin
          next_q.st = uart_pkg::TX_DATA;
          next_q.txd = q.shift[0];
          next_q.hold_full = 1'b0;
        end
      end
      uart_pkg::TX_DATA: begin
        if (bit_tick) begin
          next_q.shift = {1'b0, q.shift[7:1]};
          next_q.bit_cnt = q.bit_cnt + 3'h1;
          next_q.txd = q.shift[1];
          if (q.bit_cnt == `DATA_LAST) begin
            next_q.st = uart_pkg::TX_STOP;
            next_q.txd = `IDLE_LINE;
          end
        end
      end
      uart_pkg::TX_STOP: begin
        if (bit_tick) begin
          next_q.st = uart_pkg::TX_IDLE;
        end
      end
      default: begin
        next_q.st = uart_pkg::TX_IDLE;
        next_q.txd = `IDLE_LINE;
      end
    endcase
    // Disable wins over any start or load in the same cycle.
    if (tx_disable_cmd) begin
      next_q.tx_on = 1'b0;
      if (early || (q.st == uart_pkg::TX_IDLE)) begin
        next_q.st = uart_pkg::TX_IDLE;
        next_q.txd = `IDLE_LINE;
        next_q.hold_full = 1'b0;
      end else if (q.st != uart_pkg::TX_START) begin
        next_q.hold_full = 1'b0;
      end
    end
    if (rx_enable_cmd) begin
      next_q.rx_on = 1'b1;
    end
    if ((rx_disable_cmd || rx_reset_cmd) && !wake) begin
      next_q.rx_on = 1'b0;
      next_q.rx_rst = rx_reset_cmd;
    end
    next_q.test_out = port_test_mode ? {tx_tick, bit_tick, rx_clock_tick, q.shift[0]} :
                      4'h0;
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      q <= '0;
      q.test_mode <= `TEST_MODE_RST;
      q.st <= uart_pkg::TX_IDLE;
      q.txd <= `IDLE_LINE;
      q.ext_s1 <= 1'b0;
    end else begin
      q <= next_q;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign baud_test_mode = q.test_mode;
  assign tx_holding_free_flag = !q.hold_full;
  assign tx_shifter_empty_flag = (q.st == uart_pkg::TX_IDLE);
  assign rx_enabled = q.rx_on;
  assign rx_reset_pulse = q.rx_rst;
  assign txd = q.txd;
  assign test_port_out = q.test_out;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence start_done_s;
    (q.st == uart_pkg::TX_START) ##1 (q.st == uart_pkg::TX_DATA);
  endsequence

  test_toggle_a: assert property (test_toggle_read |=>
    (baud_test_mode != $past(baud_test_mode)))
    else $error("test mode did not toggle on read");
  reset_normal_a: assert property ($rose(resetn) |-> !baud_test_mode)
    else $error("test mode set after reset");
  empty_underrun_a: assert property ((q.st == uart_pkg::TX_IDLE) && !tx_disable_cmd
    |-> tx_shifter_empty_flag ##1 (tx_shifter_empty_flag || !txd))
    else $error("empty flag low in underrun");
  free_at_end_a: assert property (start_done_s |-> tx_holding_free_flag)
    else $error("holding free flag not set after start bit");
  shift_load_a: assert property ($rose(q.st == uart_pkg::TX_START) |->
    (q.shift == $past(q.hold_data)) && !txd)
    else $error("shifter not loaded at start bit");
  early_abort_a: assert property (tx_disable_cmd && early |=>
    txd && (q.st == uart_pkg::TX_IDLE) ##1 txd)
    else $error("early disable still sent a character");
  discard_char_a: assert property (tx_disable_cmd && q.hold_full &&
    (q.st == uart_pkg::TX_IDLE) |=> tx_holding_free_flag && tx_shifter_empty_flag)
    else $error("pending character not discarded");
  wake_hold_a: assert property (wake && rx_enabled |=> rx_enabled && !rx_reset_pulse)
    else $error("receiver dropped in wake-up mode");
  rx_reset_a: assert property (rx_reset_cmd && !wake |=> !rx_enabled && rx_reset_pulse)
    else $error("receiver reset not applied");

endmodule

// [hdl/uart_cfg.svh]
// Constants for the baud selection and transmit/receive control block.
// Assumes a single 200 MHz clock; included by bare name.
`ifndef UART_CFG_SVH
`define UART_CFG_SVH

// ****************************************************************
// Timing
// ****************************************************************
`define CLK_HZ 32'd200000000
`define CLK_PERIOD_NS 5
`define EARLY_16X 4'h3
`define SUB_LAST 4'hf
`define DATA_LAST 3'h7

// ****************************************************************
// Codes and reset values
// ****************************************************************
`define CSEL_TIMER 4'hd
`define CSEL_EXT16 4'he
`define CSEL_EXT1 4'hf
`define WAKE_MODE 2'h3
`define TEST_MODE_RST 1'b0
`define IDLE_LINE 1'b1

`endif

// [hdl/uart_pkg.sv]
// Types shared by the baud selection and transmit/receive control block.
// Assumes uart_cfg.svh is on the include path.
package uart_pkg;

  // ****************************************************************
  // Transmitter sequencing
  // ****************************************************************
  typedef enum logic [3:0] {
    TX_IDLE = 4'b0001,
    TX_START = 4'b0010,
    TX_DATA = 4'b0100,
    TX_STOP = 4'b1000
  } tx_state_t;

  // ****************************************************************
  // Clock source of one direction
  // ****************************************************************
  typedef enum logic [2:0] {
    SRC_GEN = 3'b001,
    SRC_TIMER = 3'b010,
    SRC_EXT = 3'b100
  } clk_src_t;

endpackage

// [hdl/baud_select.sv]
// Clock select decoder and rate divider for one direction.
// Assumes timer_tick and ext_edge are one-cycle pulses on clk.
`timescale 1ns/10ps
`include "uart_cfg.svh"

module baud_select (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Selection
  input wire logic [3:0] code,
  input wire logic rate_set,
  input wire logic test_mode,
  input wire logic force_1x,
  // Alternate sources
  input wire logic timer_tick,
  input wire logic ext_edge,
  // Rate out
  output logic tick,
  output logic one_x
);

  typedef struct packed {
    logic [17:0] cnt;
    logic tick;
    logic one_x;
  } sel_state_t;

  sel_state_t q;
  sel_state_t next_q;
  uart_pkg::clk_src_t src;
  logic [17:0] div;

  // ****************************************************************
  // Rate table, baud times ten
  // ****************************************************************
  // Fractional divisors are truncated; the error is far inside async tolerance.
  function automatic logic [31:0] baud_x10(input logic [3:0] c, input logic s,
                                           input logic t);
    logic [31:0] b;
    b = 32'd96000;
    case (c)
      4'h0: b = t ? (s ? 32'd72000 : 32'd48000) : (s ? 32'd750 : 32'd500);
      4'h1: b = t ? 32'd8800 : 32'd1100;
      4'h2: b = t ? 32'd10760 : 32'd1345;
      4'h3: b = t ? (s ? 32'd144000 : 32'd192000) : (s ? 32'd1500 : 32'd2000);
      4'h4: b = t ? 32'd288000 : 32'd3000;
      4'h5: b = t ? 32'd576000 : 32'd6000;
      4'h6: b = t ? 32'd1152000 : 32'd12000;
      4'h7: b = s ? 32'd20000 : 32'd10500;
      4'h8: b = t ? 32'd576000 : 32'd24000;
      4'h9: b = 32'd48000;
      4'ha: b = t ? (s ? 32'd144000 : 32'd576000) : (s ? 32'd18000 : 32'd72000);
      4'hb: b = 32'd96000;
      4'hc: b = s ? 32'd192000 : 32'd384000;
      default: b = 32'd96000;
    endcase
    return b;
  endfunction

  always_comb begin
    div = 18'((`CLK_HZ * 32'd10) / (32'd16 * baud_x10(code, rate_set, test_mode)));
    case (code)
      `CSEL_TIMER: src = uart_pkg::SRC_TIMER;
      `CSEL_EXT16, `CSEL_EXT1: src = uart_pkg::SRC_EXT;
      default: src = uart_pkg::SRC_GEN;
    endcase
  end

  always_comb begin
    next_q = q;
    next_q.tick = 1'b0;
    next_q.one_x = (code == `CSEL_EXT1) || force_1x;
    case (src)
      uart_pkg::SRC_TIMER: next_q.tick = timer_tick;
      uart_pkg::SRC_EXT: next_q.tick = ext_edge;
      default: begin
        if (q.cnt >= div - 18'h1) begin
          next_q.cnt = 18'h0;
          next_q.tick = 1'b1;
        end else begin
          next_q.cnt = q.cnt + 18'h1;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign tick = q.tick;
  assign one_x = q.one_x;

  // ****************************************************************
  // Checks
  // ****************************************************************
  timer_route_a: assert property (@(posedge clk) disable iff (!resetn)
    (code == `CSEL_TIMER) && $stable(code) |=> (tick == $past(timer_tick)))
    else $error("timer code does not pass the timer tick");

endmodule

// [tb/serial_station.sv]
// Remote serial station: makes a free running 1x clock and decodes frames on the line.
// Assumes 1 start, 8 data bits LSB first and 1 stop, with bits launched on the rising edge.
`timescale 1ns/10ps
module serial_station #(
  parameter int HALF_NS = 50
) (
  // Clock towards the device
  output logic ext_clock_pin,
  // Line from the device
  input wire logic txd,
  // Decoded characters
  output logic [7:0] rx_byte,
  output int rx_count
);
  // ****************************************************************
  // Clock and frame decoder
  // ****************************************************************
  int pos;
  logic [7:0] shift;
  initial begin
    ext_clock_pin = 1'b0;
    rx_byte = 8'h00;
    rx_count = 0;
    pos = 0;
    shift = 8'h00;
    forever #(HALF_NS) ext_clock_pin = ~ext_clock_pin;
  end
  // Sampling on the falling edge lands in mid-bit, clear of the launch delay.
  always @(negedge ext_clock_pin) begin
    if (pos == 0) begin
      if (txd === 1'b0) pos <= 1;
    end else if (pos < 9) begin
      shift <= {txd, shift[7:1]};
      pos <= pos + 1;
    end else begin
      if (txd === 1'b1) begin
        rx_byte <= shift;
        rx_count <= rx_count + 1;
      end
      pos <= 0;
    end
  end
endmodule

// [tb/uart_baud_select_txrx_control_tb.sv]
// Self-checking bench for the baud selection and transmit/receive control block.
// Assumes the serial station supplies the external clock pin with a 100 ns period.
`timescale 1ns/10ps
module uart_baud_select_txrx_control_tb;
  // ****************************************************************
  // Signals and models
  // ****************************************************************
  logic clk, resetn, rate_set, port_test, timer_tick, ext_clk;
  logic [3:0] csel_tx, csel_rx, tp;
  logic [1:0] tdiv, wake;
  logic [6:0] stb;
  logic [7:0] hdata, rx_byte;
  logic test_mode, free, empty, rx_en, rx_rst, rx_tick, rx_1x, txd;
  int rx_count, n_fail, n_compared, n, low, hi;
  uart_baud_select_txrx_control uart_baud_select_txrx_control_inst (.clk(clk),
    .resetn(resetn), .clock_select_tx(csel_tx), .clock_select_rx(csel_rx),
    .aux_control_rate_set(rate_set), .test_toggle_read(stb[0]), .port_test_mode(port_test),
    .timer_tick(timer_tick), .ext_clock_pin(ext_clk), .tx_enable_cmd(stb[1]),
    .tx_disable_cmd(stb[2]), .holding_load(stb[3]), .holding_data(hdata),
    .rx_enable_cmd(stb[4]), .rx_disable_cmd(stb[5]), .rx_reset_cmd(stb[6]),
    .mode_reg_one_wake(wake), .baud_test_mode(test_mode), .tx_holding_free_flag(free),
    .tx_shifter_empty_flag(empty), .rx_enabled(rx_en), .rx_reset_pulse(rx_rst),
    .rx_clock_tick(rx_tick), .rx_one_x(rx_1x), .txd(txd), .test_port_out(tp));
  serial_station serial_station_inst (.ext_clock_pin(ext_clk), .txd(txd),
    .rx_byte(rx_byte), .rx_count(rx_count));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // A timer tick every fourth cycle gives a short 16x bit of 64 cycles.
  always @(posedge clk) begin
    tdiv <= tdiv + 2'h1;
    timer_tick <= (tdiv == 2'h3);
  end
  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic strobe(input logic [6:0] s);
    @(posedge clk) stb <= s;
    @(posedge clk) stb <= 7'h00;
    #1;
  endtask
  task automatic step();
    @(posedge clk);
    #1;
    n++;
  endtask
  task automatic rate(input logic [3:0] c, input logic r, input int exp);
    @(posedge clk) begin
      csel_rx <= c;
      rate_set <= r;
    end
    repeat (3) begin
      n = 0;
      do step(); while (rx_tick !== 1'b1 && n < 20000);
    end
    check(16'(n), 16'(exp));
  endtask
  task automatic quiet(input int cycles);
    low = 0;
    repeat (cycles) begin
      step();
      if (txd !== 1'b1) low++;
    end
    check(16'(low), 16'h0000);
  endtask
  task automatic finish_test();
    $display("Compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    #200000;
    n_fail++;
    $display("Error at %0t: run timed out", $time);
    finish_test();
  end
  initial begin
    n_fail = 0;
    n_compared = 0;
    {resetn, rate_set, port_test, timer_tick, tdiv, wake, stb, hdata} = '0;
    csel_tx = 4'hf;
    csel_rx = 4'hc;
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    #1;
    check(16'(test_mode), 16'h0000);
    check({free, empty, txd}, 16'h0007);
    rate(4'hc, 1'b0, 325);
    rate(4'hc, 1'b1, 651);
    rate(4'hd, 1'b0, 4);
    rate(4'he, 1'b0, 20);
    strobe(7'h01);
    check(16'(test_mode), 16'h0001);
    rate(4'h6, 1'b0, 108);
    rate(4'h3, 1'b1, 868);
    rate(4'hc, 1'b0, 325);
    strobe(7'h01);
    check(16'(test_mode), 16'h0000);
    @(posedge clk) begin
      port_test <= 1'b1;
      csel_rx <= 4'hd;
    end
    repeat (4) step();
    check(16'(rx_1x), 16'h0001);
    low = 0;
    hi = 0;
    repeat (40) begin
      step();
      low += int'(tp[1]);
      hi += int'(tp[3]);
    end
    check(16'(low), 16'h000a);
    check(16'(hi), 16'h0002);
    @(posedge clk) port_test <= 1'b0;
    repeat (4) step();
    check(16'(rx_1x), 16'h0000);
    check(16'(tp), 16'h0000);
    strobe(7'h02);
    check(16'(empty), 16'h0001);
    @(posedge clk) hdata <= 8'ha5;
    strobe(7'h08);
    check(16'(free), 16'h0000);
    n = 0;
    while (txd !== 1'b0 && n < 100) step();
    n = 0;
    while (free !== 1'b1 && n < 100) step();
    check(16'(n >= 18 && n <= 22), 16'h0001);
    n = 0;
    while (rx_count != 1 && n < 400) step();
    check(rx_byte, 16'h00a5);
    repeat (40) step();
    check({free, empty}, 16'h0003);
    strobe(7'h04);
    // The pin-derived 16x clock keeps the aborted start bit clear of the station's sample.
    @(posedge clk) csel_tx <= 4'he;
    strobe(7'h02);
    strobe(7'h08);
    n = 0;
    while (txd !== 1'b0 && n < 400) step();
    check(16'(txd), 16'h0000);
    strobe(7'h04);
    quiet(300);
    check({free, empty}, 16'h0003);
    @(posedge clk) csel_tx <= 4'hf;
    strobe(7'h02);
    strobe(7'h08);
    strobe(7'h04);
    quiet(300);
    check(16'(rx_count), 16'h0001);
    strobe(7'h10);
    strobe(7'h40);
    check({rx_en, rx_rst}, 16'h0001);
    strobe(7'h10);
    check({rx_en, rx_1x}, 16'h0002);
    @(posedge clk) wake <= 2'h3;
    strobe(7'h40);
    check({rx_en, rx_rst}, 16'h0002);
    strobe(7'h20);
    check(16'(rx_en), 16'h0001);
    @(posedge clk) wake <= 2'h1;
    strobe(7'h40);
    check({rx_en, rx_rst}, 16'h0001);
    @(posedge clk) wake <= 2'h3;
    finish_test();
  end
endmodule
